// >>> logic/vfe_top.sv
// VME input filter settings, acknowledge delay and master exception capture.
// Assumes an APB master on pclk and exception inputs from master logic on pclk.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps

module vfe_top
	import vfe_pkg::*;
#(
	parameter int ADDR_W  = 12,
	parameter int RUN_LEN = FILT_RUN_LEN
) (
	// Clock, reset, enable
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               ce,
	// APB slave
	input wire logic [ADDR_W-1:0]  paddr,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [31:0]        pwdata,
	input wire logic [3:0]         pstrb,
	output logic     [31:0]        prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   irq,
	// Raw VME pins, active low
	input wire logic [3:0]         vme_bg_in_n,
	input wire logic               vme_iack_in_n,
	input wire logic [3:0]         vme_br_n,
	input wire logic               vme_bclr_n,
	input wire logic               vme_bbsy_n,
	input wire logic               vme_dtack_n,
	input wire logic               vme_berr_n,
	input wire logic               vme_retry_n,
	input wire logic               vme_as_n,
	input wire logic               vme_ds0_n,
	input wire logic               vme_ds1_n,
	// Conditioned VME levels, active low
	output logic     [3:0]         flt_bg_in_n,
	output logic                   flt_iack_in_n,
	output logic     [3:0]         flt_br_n,
	output logic                   flt_bclr_n,
	output logic                   flt_bbsy_n,
	output logic                   flt_dtack_n,
	output logic                   flt_berr_n,
	output logic                   flt_retry_n,
	output logic                   flt_as_n,
	output logic                   flt_ds0_n,
	output logic                   flt_ds1_n,
	// Acknowledge drive: dtack, berr, retry
	input wire logic [2:0]         slave_ack_req,
	output logic     [2:0]         ack_drive,
	// Master exception report
	input wire logic               exc_event,
	input wire logic               exc_master,
	input wire logic [2:0]         exc_cause,
	input wire logic [63:0]        exc_addr,
	input wire logic               exc_lword,
	input wire logic               exc_write,
	input wire logic               exc_iack,
	input wire logic               exc_ds1,
	input wire logic               exc_ds0,
	input wire logic [5:0]         exc_am,
	input wire logic [7:0]         exc_xam
);
	localparam int SEL_CTRL = 0;
	localparam int SEL_HI   = 1;
	localparam int SEL_LO   = 2;
	localparam int SEL_ATTR = 3;
	localparam int SEL_STS  = 4;
	localparam int SEL_EN   = 5;
	localparam int SEL_CLR  = 6;

	function automatic logic [6:0] reg_decode(input logic [ADDR_W-1:0] a);
		logic [6:0] s;
		s = 7'h00;
		if (a == ADDR_W'(OFF_FILTER_CTRL)) begin
			s[SEL_CTRL] = 1'b1;
		end else if (a == ADDR_W'(OFF_EXC_ADDR_HI)) begin
			s[SEL_HI] = 1'b1;
		end else if (a == ADDR_W'(OFF_EXC_ADDR_LO)) begin
			s[SEL_LO] = 1'b1;
		end else if (a == ADDR_W'(OFF_EXC_ATTR)) begin
			s[SEL_ATTR] = 1'b1;
		end else if (a == ADDR_W'(OFF_IRQ_STATUS)) begin
			s[SEL_STS] = 1'b1;
		end else if (a == ADDR_W'(OFF_IRQ_ENABLE)) begin
			s[SEL_EN] = 1'b1;
		end else if (a == ADDR_W'(OFF_IRQ_CLEAR)) begin
			s[SEL_CLR] = 1'b1;
		end
		return s;
	endfunction : reg_decode

	// Register state
	logic [31:0]          ctrl_q,  ctrl_d;
	logic [31:0]          hi_q,    hi_d;
	logic [31:0]          lo_q,    lo_d;
	logic [ATR_CAP_W-1:0] attr_q,  attr_d;
	logic                 valid_q, valid_d;
	logic                 ovf_q,   ovf_d;
	logic [IRQ_W-1:0]     sts_q,   sts_d;
	logic [IRQ_W-1:0]     en_q,    en_d;
	logic                 irq_d;
	logic [31:0]          rdata_d;
	logic                 ready_d;
	logic                 err_d;

	logic [6:0]           sel;
	logic [31:0]          wmask;
	logic                 acc;
	logic                 wr;
	logic                 clr_w;
	logic                 exc_fire;
	logic                 cap;
	logic                 ovf_ev;
	logic [PIN_N-1:0]     raw_all;
	logic [PIN_N-1:0]     filt_all;
	logic [GRP_N-1:0]     grp_en;

	// APB decode and answer, one wait state
	always_comb begin
		sel     = reg_decode(paddr);
		wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
		acc     = psel && penable && !pready;
		wr      = psel && penable && pready && pwrite && !pslverr;
		ready_d = acc;
		err_d   = acc && (sel == 7'h00);
		rdata_d = 32'h0;
		if (acc && !pwrite) begin
			if (sel[SEL_CTRL]) begin
				rdata_d = ctrl_q;
			end else if (sel[SEL_HI]) begin
				rdata_d = hi_q;
			end else if (sel[SEL_LO]) begin
				rdata_d = lo_q;
			end else if (sel[SEL_ATTR]) begin
				rdata_d = {valid_q, ovf_q, 1'b0, 7'h00, attr_q};
			end else if (sel[SEL_STS]) begin
				rdata_d = {30'h0, sts_q};
			end else if (sel[SEL_EN]) begin
				rdata_d = {30'h0, en_q};
			end
		end
	end

	// Registers, capture and interrupt
	always_comb begin
		ctrl_d  = ctrl_q;
		hi_d    = hi_q;
		lo_d    = lo_q;
		attr_d  = attr_q;
		valid_d = valid_q;
		ovf_d   = ovf_q;
		en_d    = en_q;
		sts_d   = sts_q;
		cap     = 1'b0;
		ovf_ev  = 1'b0;
		if (wr && sel[SEL_CTRL]) begin
			ctrl_d = ((ctrl_q & ~wmask) | (pwdata & wmask)) & CTL_WMASK;
		end
		if (wr && sel[SEL_EN] && pstrb[0]) begin
			en_d = pwdata[IRQ_W-1:0];
		end
		if (wr && sel[SEL_CLR] && pstrb[0]) begin
			sts_d = sts_q & ~pwdata[IRQ_W-1:0];
		end
		clr_w    = wr && sel[SEL_ATTR] && pstrb[3] && pwdata[ATR_CLR_BIT];
		exc_fire = exc_event && exc_master;
		if (clr_w) begin
			valid_d = 1'b0;
			ovf_d   = 1'b0;
		end
		if (exc_fire) begin
			if (valid_q && !clr_w) begin
				ovf_d  = 1'b1;
				ovf_ev = 1'b1;
			end else begin
				cap     = 1'b1;
				valid_d = 1'b1;
			end
		end
		if (cap) begin
			hi_d   = exc_addr[63:32];
			lo_d   = {exc_addr[31:1], 1'b0};
			attr_d = {exc_cause[CAUSE_ODD], exc_cause[CAUSE_SLAVE], exc_cause[CAUSE_BERR],
				exc_lword, exc_write, exc_iack, exc_ds1, exc_ds0, exc_am, exc_xam};
		end
		sts_d[IRQ_CAPTURE]  = sts_d[IRQ_CAPTURE] | cap;
		sts_d[IRQ_OVERFLOW] = sts_d[IRQ_OVERFLOW] | ovf_ev;
		irq_d               = |(sts_q & en_q);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= CTL_RESET;
			hi_q    <= 32'h0;
			lo_q    <= 32'h0;
			attr_q  <= '0;
			valid_q <= 1'b0;
			ovf_q   <= 1'b0;
			sts_q   <= '0;
			en_q    <= '0;
			irq     <= 1'b0;
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			ctrl_q  <= ctrl_d;
			hi_q    <= hi_d;
			lo_q    <= lo_d;
			attr_q  <= attr_d;
			valid_q <= valid_d;
			ovf_q   <= ovf_d;
			sts_q   <= sts_d;
			en_q    <= en_d;
			irq     <= irq_d;
			prdata  <= rdata_d;
			pready  <= ready_d;
			pslverr <= err_d;
		end
	end

	// Pin groups and their enables
	assign raw_all = {vme_ds1_n, vme_ds0_n, vme_as_n, vme_retry_n, vme_berr_n, vme_dtack_n,
		vme_bbsy_n, vme_bclr_n, vme_br_n, vme_iack_in_n, vme_bg_in_n};
	assign grp_en  = {ctrl_q[CTL_STRB_BIT], ctrl_q[CTL_ACK_BIT], ctrl_q[CTL_BBSY_BIT],
		ctrl_q[CTL_BCLR_BIT], ctrl_q[CTL_REQ_BIT], ctrl_q[CTL_GRANT_BIT]};

	for (genvar g = 0; g < GRP_N; g++) begin : g_grp
		vfe_filt_if #(.W(GRP_W[g])) u_if ();
		assign u_if.raw = raw_all[GRP_LO[g] +: GRP_W[g]];
		assign u_if.en  = grp_en[g];
		vfe_glitch_filter #(.W(GRP_W[g]), .RUN_LEN(RUN_LEN)) u_filt (
			.pclk    (pclk),
			.presetn (presetn),
			.ce      (ce),
			.fp      (u_if.filt_side)
		);
		assign filt_all[GRP_LO[g] +: GRP_W[g]] = u_if.filt;
	end

	assign {flt_ds1_n, flt_ds0_n, flt_as_n, flt_retry_n, flt_berr_n, flt_dtack_n,
		flt_bbsy_n, flt_bclr_n, flt_br_n, flt_iack_in_n, flt_bg_in_n} = filt_all;

	vfe_ack_timer u_ack (
		.pclk        (pclk),
		.presetn     (presetn),
		.ce          (ce),
		.delay_sel   (ctrl_q[CTL_DLY_LO +: 2]),
		.ds_negated  (filt_all[PIN_DS0] && filt_all[PIN_DS1]),
		.ack_req     (slave_ack_req),
		.ack_drive_q (ack_drive)
	);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_capture_addr: assert property ((ce && exc_fire && !valid_q)
		|=> hi_q == $past(exc_addr[63:32]) && lo_q == {$past(exc_addr[31:1]), 1'b0})
		else $error("exception address not captured");
	a_valid_hold: assert property ((valid_q && !clr_w) |=> $stable(hi_q) && $stable(lo_q))
		else $error("exception address changed while valid");
	a_valid_sets: assert property ((ce && exc_fire) |=> valid_q)
		else $error("exception valid not set");
	a_overflow_keep: assert property ((ce && exc_fire && valid_q && !clr_w)
		|=> ovf_q && $stable(attr_q) && sts_q[IRQ_OVERFLOW])
		else $error("overflow not flagged or capture disturbed");
	a_clear_flags: assert property ((ce && clr_w && !exc_fire) |=> !valid_q && !ovf_q)
		else $error("exception clear did not clear flags");
	a_cause_record: assert property ((ce && exc_fire && !valid_q)
		|=> attr_q[ATR_CAUSE_LO +: 3] == $past(exc_cause) && attr_q[5:0] == $past(exc_xam[5:0]))
		else $error("exception cause not recorded");
endmodule : vfe_top

// >>> logic/vfe_pkg.sv
// Constants of the VME input filter and exception capture block.
// Assumes a 32-bit APB register port and VME pins that are active low.
package vfe_pkg;
	// Register byte offsets
	localparam logic [11:0] OFF_FILTER_CTRL = 12'h250;
	localparam logic [11:0] OFF_EXC_ADDR_HI = 12'h260;
	localparam logic [11:0] OFF_EXC_ADDR_LO = 12'h264;
	localparam logic [11:0] OFF_EXC_ATTR    = 12'h268;
	localparam logic [11:0] OFF_IRQ_STATUS  = 12'h280;
	localparam logic [11:0] OFF_IRQ_ENABLE  = 12'h284;
	localparam logic [11:0] OFF_IRQ_CLEAR   = 12'h288;

	// Filter control fields
	localparam int          CTL_DLY_LO     = 24;
	localparam int          CTL_GRANT_BIT  = 11;
	localparam int          CTL_REQ_BIT    = 10;
	localparam int          CTL_BCLR_BIT   = 9;
	localparam int          CTL_BBSY_BIT   = 8;
	localparam int          CTL_ACK_BIT    = 4;
	localparam int          CTL_STRB_BIT   = 0;
	localparam logic [31:0] CTL_RESET      = 32'h02000f00;
	localparam logic [31:0] CTL_WMASK      = 32'h03000f11;

	// Acknowledge release delay codes and counts
	localparam logic [1:0]  DLY_SLOW       = 2'h0;
	localparam logic [1:0]  DLY_MEDIUM     = 2'h1;
	localparam logic [1:0]  DLY_FAST       = 2'h2;
	localparam logic [7:0]  ACK_SLOW_CYC   = 8'h08;
	localparam logic [7:0]  ACK_MEDIUM_CYC = 8'h04;
	localparam logic [7:0]  ACK_FAST_CYC   = 8'h02;

	// Exception attribute fields
	localparam int          ATR_VALID_BIT  = 31;
	localparam int          ATR_OVF_BIT    = 30;
	localparam int          ATR_CLR_BIT    = 29;
	localparam int          ATR_CAP_W      = 22;
	localparam int          CAUSE_BERR     = 0;
	localparam int          CAUSE_SLAVE    = 1;
	localparam int          CAUSE_ODD      = 2;
	localparam int          ATR_CAUSE_LO   = 19;

	// Interrupt status bits
	localparam int          IRQ_CAPTURE    = 0;
	localparam int          IRQ_OVERFLOW   = 1;
	localparam int          IRQ_W          = 2;

	// Input filter groups: grant, request, busclear, busbusy, ack, strobe
	localparam int          FILT_RUN_LEN   = 4;
	localparam int          GRP_N          = 6;
	localparam int          PIN_N          = 17;
	localparam int          GRP_W  [GRP_N] = '{5, 4, 1, 1, 3, 3};
	localparam int          GRP_LO [GRP_N] = '{0, 5, 9, 10, 11, 14};
	localparam int          PIN_DS0        = 15;
	localparam int          PIN_DS1        = 16;
endpackage : vfe_pkg

// >>> logic/vfe_filt_if.sv
// Carrier between the top and one glitch filter group.
// Assumes the top drives raw pins and enable, the filter returns filtered levels.
`timescale 1ns/10ps
interface vfe_filt_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic         en;
	logic [W-1:0] filt;
	modport filt_side (input raw, input en, output filt);
	modport user_side (output raw, output en, input filt);
endinterface : vfe_filt_if

// >>> logic/vfe_glitch_filter.sv
// Three-stage synchroniser and run-length glitch filter for a group of pins.
// Assumes asynchronous pin inputs that idle high.
`timescale 1ns/10ps
module vfe_glitch_filter
	import vfe_pkg::*;
#(
	parameter int W       = 1,
	parameter int RUN_LEN = FILT_RUN_LEN
) (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	// Pin group
	vfe_filt_if.filt_side   fp
);
	localparam int             CW   = $clog2(RUN_LEN + 1);
	localparam logic [CW-1:0]  LAST = CW'(RUN_LEN - 1);

	logic [W-1:0]  s1_q;
	logic [W-1:0]  s2_q;
	logic [W-1:0]  s3_q;
	logic [W-1:0]  out_q;
	logic [W-1:0]  out_d;
	logic [CW-1:0] cnt_q [W];
	logic [CW-1:0] cnt_d [W];

	always_comb begin
		out_d = out_q;
		for (int i = 0; i < W; i++) begin
			cnt_d[i] = '0;
			if (s2_q[i] == s3_q[i] && s3_q[i] != out_q[i]) begin
				if (!fp.en || cnt_q[i] == LAST) begin
					out_d[i] = s3_q[i];
				end else begin
					cnt_d[i] = cnt_q[i] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q  <= '1;
			s2_q  <= '1;
			s3_q  <= '1;
			out_q <= '1;
			cnt_q <= '{default: '0};
		end else if (ce) begin
			s1_q  <= fp.raw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= out_d;
			cnt_q <= cnt_d;
		end
	end

	assign fp.filt = out_q;

	a_bypass_follow: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && !fp.en && s2_q[0] == s3_q[0]) |=> out_q[0] == $past(s3_q[0]))
		else $error("bypassed pin did not follow synchroniser");
	a_filter_run: assert property (@(posedge pclk) disable iff (!presetn)
		($changed(out_q[0]) && $past(fp.en)) |-> $past(cnt_q[0]) == LAST)
		else $error("filtered pin changed before full run");
endmodule : vfe_glitch_filter

// >>> logic/vfe_ack_timer.sv
// Holds acknowledge drive after data strobe negation for the selected delay.
// Assumes the strobe level comes from the filtered pins on the same clock.
`timescale 1ns/10ps
module vfe_ack_timer
	import vfe_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	// Control
	input wire logic [1:0]  delay_sel,
	input wire logic        ds_negated,
	input wire logic [2:0]  ack_req,
	// Drive
	output logic     [2:0]  ack_drive_q
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [7:0] lim;
	logic [2:0] drive_d;

	always_comb begin
		if (delay_sel == DLY_SLOW) begin
			lim = ACK_SLOW_CYC;
		end else if (delay_sel == DLY_MEDIUM) begin
			lim = ACK_MEDIUM_CYC;
		end else begin
			lim = ACK_FAST_CYC;
		end
		drive_d = ack_drive_q;
		cnt_d   = '0;
		if (!ds_negated) begin
			drive_d = ack_req;
		end else if (ack_drive_q != 3'h0) begin
			if (cnt_q >= lim) begin
				drive_d = 3'h0;
			end else begin
				cnt_d = cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_drive_q <= 3'h0;
			cnt_q       <= 8'h00;
		end else if (ce) begin
			ack_drive_q <= drive_d;
			cnt_q       <= cnt_d;
		end
	end

	a_ack_release: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && ds_negated && ack_drive_q != 3'h0 && cnt_q < lim) |=> ack_drive_q == $past(ack_drive_q))
		else $error("acknowledge released before its delay");
endmodule : vfe_ack_timer

// >>> test/vfe_vme_peer.sv
// Far side of the VME pins: other masters, slaves and the system controller.
// Assumes the bench sets pin levels after a rising edge; pins idle high by pull-ups.
`timescale 1ns/10ps
module vfe_vme_peer (
	// Clock
	input wire logic        pclk,
	// Commanded levels and glitch request
	input wire logic [16:0] lvl,
	input wire logic [16:0] glitch_mask,
	input wire logic        glitch_go,
	// Pins toward the block, active low
	output logic     [16:0] pins_n
);
	logic [1:0] left_q = 2'h0;

	// Noise burst of three cycles on the chosen pins
	always_ff @(posedge pclk) begin
		if (glitch_go) begin
			left_q <= 2'h3;
		end else if (left_q != 2'h0) begin
			left_q <= left_q - 2'h1;
		end
	end

	assign pins_n = lvl & ~((left_q != 2'h0) ? glitch_mask : 17'h0);
endmodule : vfe_vme_peer

// >>> test/tb_top.sv
// Self-checking bench of the VME filter and exception capture block.
// Assumes an APB master here and the pin peer model beside the block.
`timescale 1ns/10ps
module tb_top
	import vfe_pkg::*;
();
	logic        pclk, presetn, ce, psel, penable, pwrite, exc_event, exc_master, err, go;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [3:0]  pstrb;
	logic [16:0] lvl, gmask;
	logic [2:0]  slave_ack_req, exc_cause;
	logic [63:0] exc_addr;
	logic [18:0] exa;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq;
	wire  [2:0]  ack_drive;
	wire  [16:0] pins, fltv;
	int          failures, checks;
	localparam int GBIT [GRP_N] = '{CTL_GRANT_BIT, CTL_REQ_BIT, CTL_BCLR_BIT, CTL_BBSY_BIT, CTL_ACK_BIT, CTL_STRB_BIT};

	vfe_vme_peer i_vfe_vme_peer (.pclk(pclk), .lvl(lvl), .glitch_mask(gmask), .glitch_go(go), .pins_n(pins));

	vfe_top #(.ADDR_W(12), .RUN_LEN(4)) i_vfe_top (
		.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .vme_bg_in_n(pins[3:0]), .vme_iack_in_n(pins[4]),
		.vme_br_n(pins[8:5]), .vme_bclr_n(pins[9]), .vme_bbsy_n(pins[10]), .vme_dtack_n(pins[11]),
		.vme_berr_n(pins[12]), .vme_retry_n(pins[13]), .vme_as_n(pins[14]), .vme_ds0_n(pins[15]),
		.vme_ds1_n(pins[16]), .flt_bg_in_n(fltv[3:0]), .flt_iack_in_n(fltv[4]), .flt_br_n(fltv[8:5]),
		.flt_bclr_n(fltv[9]), .flt_bbsy_n(fltv[10]), .flt_dtack_n(fltv[11]), .flt_berr_n(fltv[12]),
		.flt_retry_n(fltv[13]), .flt_as_n(fltv[14]), .flt_ds0_n(fltv[15]), .flt_ds1_n(fltv[16]),
		.slave_ack_req(slave_ack_req), .ack_drive(ack_drive), .exc_event(exc_event),
		.exc_master(exc_master), .exc_cause(exc_cause), .exc_addr(exc_addr), .exc_lword(exa[18]),
		.exc_write(exa[17]), .exc_iack(exa[16]), .exc_ds1(exa[15]), .exc_ds0(exa[14]),
		.exc_am(exa[13:8]), .exc_xam(exa[7:0])
	);

	always #12.5 pclk = ~pclk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up

	// Setup, access, then hold until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin @(posedge pclk); end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdchk

	task automatic settle(input logic [16:0] m, input logic v, output int n);
		n = 0;
		do begin @(posedge pclk); #1; n++; end while ((fltv & m) !== (v ? m : 17'h0) && n < 40);
	endtask : settle

	task automatic glitch(input logic [16:0] m, output logic seen);
		@(posedge pclk); gmask <= m; go <= 1'b1;
		@(posedge pclk); go <= 1'b0;
		seen = 1'b0;
		repeat (12) begin @(posedge pclk); #1; if ((fltv & m) !== m) seen = 1'b1; end
	endtask : glitch

	task automatic exc(input logic mst, input logic [2:0] cs, input logic [63:0] a, input logic [18:0] at);
		@(posedge pclk);
		exc_event <= 1'b1; exc_master <= mst; exc_cause <= cs; exc_addr <= a; exa <= at;
		@(posedge pclk); exc_event <= 1'b0;
	endtask : exc

	task automatic t_regs;
		rdchk(OFF_FILTER_CTRL, CTL_RESET);
		rdchk(OFF_EXC_ADDR_HI, 32'h0);
		rdchk(OFF_EXC_ADDR_LO, 32'h0);
		rdchk(OFF_EXC_ATTR, 32'h0);
		apb(1'b0, 12'h2f0, 32'h0);
		check(32'(err), 32'h1);
		check(rd, 32'h0);
		wr(OFF_EXC_ADDR_HI, 32'hffffffff);
		rdchk(OFF_EXC_ADDR_HI, 32'h0);
		wr(OFF_FILTER_CTRL, 32'hffffffff);
		rdchk(OFF_FILTER_CTRL, CTL_WMASK);
		pstrb <= 4'h2;
		wr(OFF_FILTER_CTRL, 32'h0);
		pstrb <= 4'hf;
		rdchk(OFF_FILTER_CTRL, 32'h03000011);
		$display("test registers done");
	endtask : t_regs

	task automatic t_filters;
		int n;
		logic [16:0] m;
		logic s;
		for (int g = 0; g < GRP_N; g++) begin
			m = 17'(((1 << GRP_W[g]) - 1) << GRP_LO[g]);
			wr(OFF_FILTER_CTRL, 32'h02000000);
			@(posedge pclk); lvl <= ~m; settle(m, 1'b0, n);
			check(32'(n), 32'h4);
			@(posedge pclk); lvl <= '1; settle(m, 1'b1, n);
			glitch(m, s);
			check(32'(s), 32'h1);
			wr(OFF_FILTER_CTRL, 32'h02000000 | (32'h1 << GBIT[g]));
			@(posedge pclk); lvl <= ~m; settle(m, 1'b0, n);
			check(32'(n), 32'h7);
			@(posedge pclk); lvl <= '1; settle(m, 1'b1, n);
			glitch(m, s);
			check(32'(s), 32'h0);
		end
		$display("test filters done");
	endtask : t_filters

	task automatic t_ack;
		int lat [4];
		int n;
		for (int c = 0; c < 4; c++) begin
			wr(OFF_FILTER_CTRL, 32'(c) << CTL_DLY_LO);
			@(posedge pclk); slave_ack_req <= 3'h7; lvl[PIN_DS0] <= 1'b0;
			n = 0;
			do begin @(posedge pclk); #1; n++; end while (ack_drive !== 3'h7 && n < 40);
			check(32'(ack_drive), 32'h7);
			@(posedge pclk); lvl[PIN_DS0] <= 1'b1;
			n = 0;
			do begin @(posedge pclk); #1; n++; end while (ack_drive !== 3'h0 && n < 60);
			lat[c] = n;
			@(posedge pclk); slave_ack_req <= 3'h0;
		end
		check(32'(lat[0] - lat[1]), 32'h4);
		check(32'(lat[1] - lat[2]), 32'h2);
		check(32'(lat[3]), 32'(lat[2]));
		$display("test ack delay done");
	endtask : t_ack

	task automatic t_exc;
		logic [63:0] a;
		logic [18:0] at;
		logic [31:0] ex;
		wr(OFF_IRQ_ENABLE, 32'h3);
		exc(1'b0, 3'h1, 64'h3, 19'h1);
		rdchk(OFF_EXC_ATTR, 32'h0);
		for (int c = 0; c < 3; c++) begin
			a = {32'h89abcdef ^ 32'(c), 32'h13579bdf + 32'(2 * c)};
			at = 19'h5a5a5 ^ 19'(c);
			ex = 32'h80000000 | (32'h1 << (ATR_CAUSE_LO + c)) | 32'(at);
			exc(1'b1, 3'h1 << c, a, at);
			rdchk(OFF_EXC_ADDR_HI, a[63:32]);
			rdchk(OFF_EXC_ADDR_LO, {a[31:1], 1'b0});
			rdchk(OFF_EXC_ATTR, ex);
			rdchk(OFF_IRQ_STATUS, 32'h1);
			check(32'(irq), 32'h1);
			exc(1'b1, 3'h7, ~a, ~at);
			rdchk(OFF_EXC_ADDR_LO, {a[31:1], 1'b0});
			rdchk(OFF_EXC_ATTR, ex | 32'h40000000);
			rdchk(OFF_IRQ_STATUS, 32'h3);
			wr(OFF_EXC_ATTR, 32'h0);
			rdchk(OFF_EXC_ATTR, ex | 32'h40000000);
			wr(OFF_EXC_ATTR, 32'h1 << ATR_CLR_BIT);
			apb(1'b0, OFF_EXC_ATTR, 32'h0);
			check(rd & 32'he0000000, 32'h0);
			wr(OFF_IRQ_CLEAR, 32'h3);
			rdchk(OFF_IRQ_STATUS, 32'h0);
			check(32'(irq), 32'h0);
		end
		wr(OFF_IRQ_ENABLE, 32'h0);
		exc(1'b1, 3'h1, 64'h5, 19'h2);
		rdchk(OFF_IRQ_STATUS, 32'h1);
		check(32'(irq), 32'h0);
		$display("test exception capture done");
	endtask : t_exc

	// Clock enable low must freeze the synchroniser and filter state
	task automatic t_ce;
		int n;
		wr(OFF_FILTER_CTRL, 32'h02000000);
		@(posedge pclk); ce <= 1'b0; lvl <= 17'h1fffe;
		repeat (8) @(posedge pclk);
		check(32'(fltv), 32'h1ffff);
		ce <= 1'b1;
		settle(17'h1, 1'b0, n);
		check(32'(n), 32'h4);
		@(posedge pclk); lvl <= '1; settle(17'h1, 1'b1, n);
		$display("test clock enable done");
	endtask : t_ce

	initial begin
		#(25ns * 40000);
		failures++;
		wrap_up;
	end

	initial begin
		pclk = 1'b0; presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h0; pwdata = 32'h0; pstrb = 4'hf; lvl = '1; gmask = 17'h0; go = 1'b0;
		slave_ack_req = 3'h0; exc_event = 1'b0; exc_master = 1'b0; exc_cause = 3'h0;
		exc_addr = 64'h0; exa = 19'h0; failures = 0; checks = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_filters;
		t_ack;
		t_exc;
		t_ce;
		wrap_up;
	end
endmodule : tb_top
